// ===== hw/ivp_cfg.svh
// Constants for the interrupt vector placement block.
`ifndef IVP_CFG_SVH
`define IVP_CFG_SVH
// Register address of interrupt_control.
`define IVP_ADDR_ICTRL 8'h00
// Field positions inside interrupt_control.
`define IVP_BIT_CE 0
`define IVP_BIT_VSEL 1
`define IVP_BIT_IRQ2 5
`define IVP_BIT_IRQ0 6
`define IVP_BIT_IRQ1 7
// Reset value of interrupt_control and the zero word.
`define IVP_ICTRL_RST 8'h00
`define IVP_RD_ZERO 8'h00
// Cycles the change window stays open after change enable is set.
`define IVP_CHG_WINDOW_CYC 3'h4
// Boot section start word addresses, one per boot size code.
`define IVP_BOOT_START_SZ0 13'h1C00
`define IVP_BOOT_START_SZ1 13'h1E00
`define IVP_BOOT_START_SZ2 13'h1F00
`define IVP_BOOT_START_SZ3 13'h1F80
// Application table start and reset address.
`define IVP_APP_BASE 13'h0000
// Programmed fuse or lock bit reads as zero.
`define IVP_PROGRAMMED 1'b0
`endif

// ===== hw/ivp_pkg.sv
// Types shared by the interrupt vector placement block.
package ivp_pkg;
    // Program word address.
    typedef logic [12:0] ivp_waddr_t;
    // Register port request from the core.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ivp_bus_s;
    // Non-volatile settings, zero meaning programmed.
    typedef struct packed {
        logic [1:0] boot_size_fuses;
        logic reset_vector_fuse;
        logic app_boot_lock;
        logic boot_side_lock;
    } ivp_fuse_s;
    // Change sequence state.
    typedef enum logic [1:0] {
        IVP_IDLE,
        IVP_WINDOW,
        IVP_HOLD
    } ivp_seq_e;
endpackage

// ===== hw/ivp_cycle_timer.sv
// Small down counter that holds a window open for a loaded number of cycles.
`timescale 1ns/10ps
module ivp_cycle_timer #(
    parameter int W = 3
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic stop_i,
    output logic active_o,
    output logic expire_o
);
    // Remaining cycles of the window.
    logic [W-1:0] count_q;

    // Load wins over stop, so a fresh request always reopens the window.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            count_q <= '0;
        else if (load_i)
            count_q <= load_val_i;
        else if (stop_i)
            count_q <= '0;
        else if (count_q != '0)
            count_q <= count_q - W'(1);
    end

    // The window is open while any count remains.
    assign active_o = (count_q != '0);
    // Last open cycle with nothing to restart or stop it.
    assign expire_o = (count_q == W'(1)) && !load_i && !stop_i;
endmodule

// ===== hw/ivp_vector_ctrl.sv
// Interrupt vector placement: control register, change sequence and vector addresses.
//
// Functional notes
// - Vector select picks flash start or boot start.
// - Boot start follows the boot size fuses.
// - Block interrupts until instruction after select write.
// - Unused window blocks interrupts four cycles only.
// - Blocking never touches the global enable bit.
// - Change enable clears after four cycles or write.
// - Boot vectors, app lock: block in application.
// - App vectors, boot lock: block in boot.
// - 2K boot, fuse clear, select: reset zero.
// - Fuse programmed, select clear: reset boot start.
// - Fuse and select: slots from boot start.
// - Vector address is table entry plus base.
`timescale 1ns/10ps
`include "ivp_cfg.svh"
module ivp_vector_ctrl (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire ivp_pkg::ivp_bus_s bus_i,
    output logic [7:0] rd_data_o,
    input wire ivp_pkg::ivp_fuse_s fuse_i,
    input wire ivp_pkg::ivp_waddr_t pc_i,
    input wire logic instr_retire_i,
    input wire logic [4:0] irq_num_i,
    output ivp_pkg::ivp_waddr_t vector_base_o,
    output ivp_pkg::ivp_waddr_t vector_addr_o,
    output ivp_pkg::ivp_waddr_t reset_addr_o,
    output logic [2:0] ext_irq_enable_o,
    output logic vector_select_o,
    output logic irq_block_o
);
    import ivp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register decode.

    // A write to the control register this cycle.
    logic ctrl_wr;
    // A read of the control register this cycle.
    logic ctrl_rd;
    // That write sets change enable.
    logic wr_ce;
    // That write clears change enable, and so may carry a new select.
    logic wr_sel;
    // Change enable as seen by software; it lives in the timer.
    logic ce_w;
    // The change window ends this cycle without a select write.
    logic ce_expire;
    // Vector select bit.
    logic vsel_q;
    // External interrupt enables, bit order 1, 0, 2 from the top.
    logic [2:0] ext_en_q;
    // Sequence state and its next value.
    ivp_seq_e seq_q;
    ivp_seq_e seq_d;
    // Boot section start decoded from the fuses.
    ivp_waddr_t boot_start_w;
    // Executing from the boot section.
    logic in_boot;
    // A boot lock forbids interrupts right now.
    logic lock_hit;
    // Registered outputs.
    logic [7:0] rd_data_q;
    ivp_waddr_t base_q;
    ivp_waddr_t vaddr_q;
    ivp_waddr_t rst_addr_q;
    logic block_q;
    // Reset image of the control register; the select bit takes its reset value from it.
    localparam logic [7:0] ictrl_rst = `IVP_ICTRL_RST;

    // Only the control register is mapped; every other address falls through.
    assign ctrl_wr = bus_i.wr && (bus_i.addr == `IVP_ADDR_ICTRL);
    assign ctrl_rd = bus_i.rd && (bus_i.addr == `IVP_ADDR_ICTRL);
    assign wr_ce = ctrl_wr && bus_i.wdata[`IVP_BIT_CE];
    assign wr_sel = ctrl_wr && !bus_i.wdata[`IVP_BIT_CE] && ce_w;

    ////////////////////////////////////////////////////////////////////////
    // Change window timer.

    // Setting change enable loads four cycles; a select write closes it early.
    ivp_cycle_timer #(
        .W(3)
    ) u_window (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .load_i(wr_ce),
        .load_val_i(`IVP_CHG_WINDOW_CYC),
        .stop_i(wr_sel),
        .active_o(ce_w),
        .expire_o(ce_expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control register bits.

    // Select only moves inside an open window, which keeps a stray write from
    // yanking the table away under a running handler.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            vsel_q <= ictrl_rst[`IVP_BIT_VSEL];
        else if (wr_sel)
            vsel_q <= bus_i.wdata[`IVP_BIT_VSEL];
    end

    // The external enables are plain read/write bits.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            ext_en_q <= '0;
        else if (ctrl_wr)
            ext_en_q <= {bus_i.wdata[`IVP_BIT_IRQ1], bus_i.wdata[`IVP_BIT_IRQ0],
                         bus_i.wdata[`IVP_BIT_IRQ2]};
    end

    ////////////////////////////////////////////////////////////////////////
    // Change sequence.

    // A new change enable always restarts the window, even from hold.
    always_comb
    begin
        seq_d = seq_q;
        case (seq_q)
            IVP_IDLE:
            begin
                if (wr_ce)
                    seq_d = IVP_WINDOW;
            end
            IVP_WINDOW:
            begin
                if (wr_ce)
                    seq_d = IVP_WINDOW;
                else if (wr_sel)
                    seq_d = IVP_HOLD;
                else if (ce_expire)
                    seq_d = IVP_IDLE;
            end
            IVP_HOLD:
            begin
                // The next retired instruction is the one after the write.
                if (wr_ce)
                    seq_d = IVP_WINDOW;
                else if (instr_retire_i)
                    seq_d = IVP_IDLE;
            end
            default:
                seq_d = IVP_IDLE;
        endcase
    end

    // Sequence state register.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            seq_q <= IVP_IDLE;
        else
            seq_q <= seq_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot section decode and lock blocking.

    // Boot start is a pure function of the fuses.
    always_comb
    begin
        case (fuse_i.boot_size_fuses)
            2'h0: boot_start_w = `IVP_BOOT_START_SZ0;
            2'h1: boot_start_w = `IVP_BOOT_START_SZ1;
            2'h2: boot_start_w = `IVP_BOOT_START_SZ2;
            default: boot_start_w = `IVP_BOOT_START_SZ3;
        endcase
    end

    // The boot section runs from its start to the top of flash.
    assign in_boot = (pc_i >= boot_start_w);

    // A table placed in the other section than the code is unreachable when
    // that section is locked, so interrupts must not fire there.
    assign lock_hit = (vsel_q && (fuse_i.app_boot_lock == `IVP_PROGRAMMED) && !in_boot)
                   || (!vsel_q && (fuse_i.boot_side_lock == `IVP_PROGRAMMED) && in_boot);

    // The block is a separate gate into the core; the global enable bit in the
    // status register is left alone, so nothing needs restoring afterwards.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            block_q <= 1'b0;
        else
            block_q <= (seq_d != IVP_IDLE) || lock_hit;
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector and reset addresses.

    // Table base: application start or boot start.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            base_q <= `IVP_APP_BASE;
        else
            base_q <= vsel_q ? boot_start_w : `IVP_APP_BASE;
    end

    // Each vector takes a two-word slot; the slot number is the entry index.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            vaddr_q <= `IVP_APP_BASE;
        else
            vaddr_q <= (vsel_q ? boot_start_w : `IVP_APP_BASE) + {7'h00, irq_num_i, 1'b0};
    end

    // Reset fetch follows the reset vector fuse and the boot size fuses, never the select bit.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            rst_addr_q <= `IVP_APP_BASE;
        else if (fuse_i.reset_vector_fuse == `IVP_PROGRAMMED)
            rst_addr_q <= boot_start_w;
        else
            rst_addr_q <= `IVP_APP_BASE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port.

    // Read data stand one cycle after the strobe; other addresses read zero.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            rd_data_q <= `IVP_RD_ZERO;
        else if (ctrl_rd)
            rd_data_q <= {ext_en_q[2], ext_en_q[1], ext_en_q[0], 3'h0, vsel_q, ce_w};
        else
            rd_data_q <= `IVP_RD_ZERO;
    end

    // Every output is the flip-flop behind it, with no logic after it.
    assign rd_data_o = rd_data_q;
    assign vector_base_o = base_q;
    assign vector_addr_o = vaddr_q;
    assign reset_addr_o = rst_addr_q;
    assign ext_irq_enable_o = ext_en_q;
    assign vector_select_o = vsel_q;
    assign irq_block_o = block_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Change enable written, then four quiet cycles.
    sequence s_open_quiet;
        wr_ce ##1 (!bus_i.wr)[*4];
    endsequence

    // A window opened and a select written on the next cycle.
    sequence s_open_sel;
        wr_ce ##1 (ctrl_wr && !bus_i.wdata[`IVP_BIT_CE]);
    endsequence

    // A select write, then at once a retiring instruction with no lock or new window.
    sequence s_sel_retire;
        wr_sel ##1 (instr_retire_i && !wr_ce && !lock_hit);
    endsequence

    // The window closes by itself after four cycles.
    a_ce_self_clear: assert property (s_open_quiet |=> !ce_w)
        else $error("change enable outlived four cycles");

    // The window stays open through its third cycle.
    a_ce_held_open: assert property (wr_ce ##1 (!bus_i.wr)[*3] |-> ce_w)
        else $error("change enable dropped early");

    // Change enable stands right after it is written.
    a_ce_on_set: assert property (wr_ce |=> ce_w)
        else $error("change enable not set by its write");

    // An unused window stops blocking in its fifth cycle.
    a_block_timeout: assert property (s_open_quiet |=> (seq_q == IVP_IDLE))
        else $error("sequence block not released after window");

    // Blocking begins in the cycle after change enable is set.
    a_block_on_set: assert property (wr_ce |=> irq_block_o)
        else $error("interrupts not blocked when change enable set");

    // Blocking outlasts the select write until an instruction retires.
    a_block_until_retire: assert property (s_open_sel ##1 !instr_retire_i |=> irq_block_o)
        else $error("block released before following instruction");

    // The instruction retiring after the select write ends the block.
    a_hold_release: assert property (s_sel_retire |=> !irq_block_o)
        else $error("block held after the following instruction");

    // A select write inside the window takes its value and closes the window.
    a_sel_takes_value: assert property (s_open_sel |=> vsel_q == $past(bus_i.wdata[`IVP_BIT_VSEL]) && !ce_w)
        else $error("select not taken inside window");

    // A select write without a window leaves the select alone.
    a_sel_locked: assert property (ctrl_wr && !ce_w |=> $stable(vsel_q))
        else $error("select changed outside window");

    // Boot table and application lock block the application code.
    a_app_lock_block: assert property (vsel_q && !fuse_i.app_boot_lock && !in_boot |=> irq_block_o)
        else $error("application code not blocked under lock");

    // Application table and boot lock block the boot code.
    a_boot_lock_block: assert property (!vsel_q && !fuse_i.boot_side_lock && in_boot |=> irq_block_o)
        else $error("boot code not blocked under lock");

    // A set select puts the table at the boot start.
    a_base_boot: assert property (vsel_q && $stable(fuse_i) |=> vector_base_o == $past(boot_start_w))
        else $error("vector base not at boot start");

    // A clear select keeps the table at the start of flash.
    a_base_app: assert property (!vsel_q |=> vector_base_o == `IVP_APP_BASE)
        else $error("vector base not at flash start");

    // Each slot sits two words per entry above the table base.
    a_slot_addr: assert property (1'b1 |=> vector_addr_o == vector_base_o + {7'h00, $past(irq_num_i), 1'b0})
        else $error("vector slot address wrong");

    // An unprogrammed reset fuse fetches reset from address zero.
    a_reset_fuse: assert property ($stable(fuse_i) && fuse_i.reset_vector_fuse |=> reset_addr_o == `IVP_APP_BASE)
        else $error("reset fetch not at zero");

    // A programmed reset fuse fetches reset from the boot start.
    a_reset_boot: assert property (!fuse_i.reset_vector_fuse |=> reset_addr_o == $past(boot_start_w))
        else $error("reset fetch not at boot start");

    // Select and change enable read back as they stood at the strobe.
    a_ctrl_readback: assert property (ctrl_rd |=>
        rd_data_o[`IVP_BIT_CE] == $past(ce_w) && rd_data_o[`IVP_BIT_VSEL] == $past(vsel_q))
        else $error("control bits read back wrong");

    // Outside a read of the register the read data rest at zero.
    a_rd_idle_zero: assert property (!ctrl_rd |=> rd_data_o == `IVP_RD_ZERO)
        else $error("read data not zero outside a read");

    // The reserved bits never read as one.
    a_reserved_zero: assert property (rd_data_o[4:2] == 3'h0)
        else $error("reserved bits read nonzero");
endmodule

// ===== bench/ivp_vector_ctrl_tb.sv
// Self-checking testbench for the interrupt vector placement block.
`timescale 1ns/10ps
`include "ivp_cfg.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module ivp_vector_ctrl_tb;
    import ivp_pkg::*;
    logic sys_clk_i = 1'b0; // Clock, 100 MHz.
    logic rst_b_i = 1'b0; // Reset held low at start.
    ivp_bus_s bus = '0; // Register port request.
    ivp_fuse_s fuse = 5'b00111; // 2K boot section, size fuses programmed, nothing else programmed.
    ivp_waddr_t pc = 13'h0000; // Program counter seen by the block.
    logic retire = 1'b0; // Instruction completion pulse.
    logic [4:0] irq_num = 5'h01; // Vector slot number.
    logic [7:0] rd_data_o;
    ivp_waddr_t vector_base_o, vector_addr_o, reset_addr_o;
    logic [2:0] ext_irq_enable_o;
    logic vector_select_o, irq_block_o;
    int num_errors = 0; // Mismatches seen.
    int cmp_count = 0; // Comparisons made.
    always #5 sys_clk_i = ~sys_clk_i;
    ivp_vector_ctrl DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rd_data_o(rd_data_o),
        .fuse_i(fuse), .pc_i(pc), .instr_retire_i(retire), .irq_num_i(irq_num),
        .vector_base_o(vector_base_o), .vector_addr_o(vector_addr_o), .reset_addr_o(reset_addr_o),
        .ext_irq_enable_o(ext_irq_enable_o), .vector_select_o(vector_select_o), .irq_block_o(irq_block_o));
    ////////////////////////////////////////////////////////////////////////////////
    // One bus cycle, launched at an edge and taken at the next one.
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        bus.wr <= w;
        bus.rd <= r;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge sys_clk_i);
    endtask
    // Read and compare; data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        op(1'b0, 1'b1, a, 8'h00);
        bus <= '0;
        @(negedge sys_clk_i);
        `CHK(rd_data_o, e)
        @(posedge sys_clk_i);
    endtask
    // Wait one edge for registered outputs, then look mid-cycle.
    task automatic settle;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    // Pulse retire for one cycle; the block releases in the next cycle.
    task automatic pulse_retire;
        retire <= 1'b1;
        @(posedge sys_clk_i);
        retire <= 1'b0;
    endtask
    // Timed change sequence that leaves select at v.
    task automatic set_sel(input logic v);
        op(1'b1, 1'b0, 8'h00, 8'h01);
        op(1'b1, 1'b0, 8'h00, {6'h00, v, 1'b0});
        bus <= '0;
        pulse_retire();
        @(posedge sys_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values of the register and of the select and block outputs.
    task automatic t_reset;
        @(negedge sys_clk_i);
        `CHK(vector_select_o, 1'b0)
        `CHK(irq_block_o, 1'b0)
        @(posedge sys_clk_i);
        rd_chk(8'h00, 8'h00);
    endtask
    // Change enable left unused: four blocked cycles, then it clears itself.
    task automatic t_expire;
        op(1'b1, 1'b0, 8'h00, 8'h01);
        bus <= '0;
        @(negedge sys_clk_i);
        `CHK(irq_block_o, 1'b1)
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        `CHK(irq_block_o, 1'b1)
        settle();
        `CHK(irq_block_o, 1'b0)
        @(posedge sys_clk_i);
        rd_chk(8'h00, 8'h00);
    endtask
    // Back-to-back enable then select write moves the table.
    task automatic t_move;
        op(1'b1, 1'b0, 8'h00, 8'h01);
        op(1'b1, 1'b0, 8'h00, 8'h02);
        bus <= '0;
        @(negedge sys_clk_i);
        `CHK(vector_select_o, 1'b1)
        `CHK(irq_block_o, 1'b1)
        @(posedge sys_clk_i);
        pulse_retire();
        @(negedge sys_clk_i);
        `CHK(irq_block_o, 1'b0)
        `CHK(vector_base_o, `IVP_BOOT_START_SZ0)
        @(posedge sys_clk_i);
        rd_chk(8'h00, 8'h02);
    endtask
    // Slots 1 through 20 of the moved table.
    task automatic t_vec;
        int n;
        for (n = 1; n <= 20; n = n + 1)
        begin
            irq_num <= n[4:0];
            settle();
            `CHK(vector_addr_o, `IVP_BOOT_START_SZ0 + 13'(2 * n))
            `CHK(reset_addr_o, 13'h0000)
            @(posedge sys_clk_i);
        end
        irq_num <= 5'h01;
    endtask
    // Reset fuse and every boot size code.
    task automatic t_size;
        ivp_waddr_t tbl[4] = '{`IVP_BOOT_START_SZ0, `IVP_BOOT_START_SZ1, `IVP_BOOT_START_SZ2, `IVP_BOOT_START_SZ3};
        int k;
        fuse.reset_vector_fuse <= `IVP_PROGRAMMED;
        for (k = 3; k >= 0; k = k - 1)
        begin
            fuse.boot_size_fuses <= k[1:0];
            settle();
            `CHK(vector_base_o, tbl[k])
            `CHK(reset_addr_o, tbl[k])
            @(posedge sys_clk_i);
        end
    endtask
    // Writes that must not touch select, reserved bits, unmapped space.
    task automatic t_refuse;
        op(1'b1, 1'b0, 8'h00, 8'hBC);
        bus <= '0;
        @(posedge sys_clk_i);
        rd_chk(8'h00, 8'hA2);
        `CHK(ext_irq_enable_o, 3'b101)
        op(1'b1, 1'b0, 8'h05, 8'hFF);
        rd_chk(8'h05, 8'h00);
        op(1'b1, 1'b0, 8'h00, 8'hFD);
        rd_chk(8'h00, 8'hE3);
        repeat (5) @(posedge sys_clk_i);
        rd_chk(8'h00, 8'hE2);
        op(1'b1, 1'b0, 8'h00, 8'h00);
        rd_chk(8'h00, 8'h02);
    endtask
    // Lock blocking depends on select and where the program runs.
    task automatic t_lock(input logic boot_lock);
        if (boot_lock)
            fuse.boot_side_lock <= `IVP_PROGRAMMED;
        else
            fuse.app_boot_lock <= `IVP_PROGRAMMED;
        pc <= 13'h0100;
        settle();
        `CHK(irq_block_o, ~boot_lock)
        @(posedge sys_clk_i);
        pc <= 13'h1C10;
        settle();
        `CHK(irq_block_o, boot_lock)
        @(posedge sys_clk_i);
        fuse.app_boot_lock <= 1'b1;
        fuse.boot_side_lock <= 1'b1;
        pc <= 13'h0000;
        @(posedge sys_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Counts, verdict and end of run.
    task automatic results;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // The whole run takes well under a thousand cycles.
    initial
    begin
        #100000;
        num_errors++;
        results();
    end
    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        t_reset();
        t_expire();
        t_move();
        t_vec();
        t_refuse();
        t_lock(1'b0);
        t_size();
        set_sel(1'b0);
        settle();
        `CHK(vector_addr_o, 13'h0002)
        `CHK(vector_base_o, 13'h0000)
        `CHK(reset_addr_o, `IVP_BOOT_START_SZ0)
        @(posedge sys_clk_i);
        t_lock(1'b1);
        results();
    end
endmodule
